// >>> rtl/opag_params.svh
/*
 * Constants for the operand and program address generator.
 * Assumes inclusion by bare name from rtl/.
 */
`ifndef OPAG_PARAMS_SVH
`define OPAG_PARAMS_SVH

`define OPAG_PC_W      23
`define OPAG_DW        16
`define OPAG_PC_STEP   23'h00_0002
`define OPAG_PC_STEP2  23'h00_0004
`define OPAG_PC_RST    23'h00_0000
`define OPAG_WORD_STEP 16'h0002
`define OPAG_BYTE_STEP 16'h0001
`define OPAG_PF_REGOFS 3'h4

`endif

// >>> rtl/opag_pkg.sv
/*
 * Types for the operand and program address generator.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package opag_pkg;
	typedef enum logic [2:0] {
		OPAG_IND_NOMOD = 3'h0,
		OPAG_IND_PREINC = 3'h1,
		OPAG_IND_PREDEC = 3'h2,
		OPAG_IND_POSTINC = 3'h3,
		OPAG_IND_POSTDEC = 3'h4,
		OPAG_IND_REGOFS = 3'h5
	} opag_ind_mode_t;

	// Prefetch: 0 none, 1..3 +2/+4/+6, 5..7 -2/-4/-6, 4 register offset
	typedef logic [2:0] opag_pf_mode_t;

	typedef enum logic [2:0] {
		OPAG_IMM_U1 = 3'h0,
		OPAG_IMM_U4 = 3'h1,
		OPAG_IMM_S4 = 3'h2,
		OPAG_IMM_U5 = 3'h3,
		OPAG_IMM_S6 = 3'h4,
		OPAG_IMM_U8 = 3'h5,
		OPAG_IMM_U10 = 3'h6,
		OPAG_IMM_S10 = 3'h7
	} opag_imm_kind_t;

	typedef enum logic [3:0] {
		OPAG_PC_SEQ = 4'h0,
		OPAG_PC_BRA = 4'h1,
		OPAG_PC_BRC = 4'h2,
		OPAG_PC_CALL_ABS = 4'h3,
		OPAG_PC_GOTO_ABS = 4'h4,
		OPAG_PC_CALL_IND = 4'h5,
		OPAG_PC_GOTO_IND = 4'h6,
		OPAG_PC_RELATIVE_SUBROUTINE_CALL = 4'h7,
		OPAG_PC_RELATIVE_SUBROUTINE_CALL_W = 4'h8,
		OPAG_PC_EXC = 4'h9,
		OPAG_PC_RET = 4'hA,
		OPAG_PC_RETURN_FROM_EXCEPTION = 4'hB,
		OPAG_PC_U14 = 4'hC,
		OPAG_PC_U16 = 4'hD
	} opag_pc_op_t;
endpackage
`default_nettype wire

// >>> rtl/opag_top.sv
/*
 * Operand effective-address, immediate and next-PC generation.
 * Assumes decoded controls from the core on clk_in; the memories take the
 * registered addresses; one flow operation per cycle.
 */
// Contract
// R1: Indirect modes no-modify, pre/post inc/dec; register offset for moves only.
// R2: MAC class makes X and Y fetches in one instruction, own addresses.
// R3: Prefetch pointers unmodified or post-modified by 2, 4 or 6 bytes.
// R4: Prefetch updates are always even, never odd sized.
// R5: X pointer from x_prefetch_ptr_a/b, Y from y_prefetch_ptr_a/b only.
// R6: Register offset prefetch adds dual_fetch_offset_reg to b pointers, no update.
// R7: Circular addressing wraps pointers at buffer bounds automatically.
// R8: Bit-reversed pointer sequencing for radix-2 FFT reordering.
// R9: Circular and bit-reversed apply to every indirect operand; code applies them to ind_ptr_in only, bit-reverse on increments only.
// R10: Immediate fields of 1,4,5,6,8,10,14,16 bits are extracted.
// R11: Signed 4, 6, 10 bit literals sign-extend; others zero-extend.
// R12: Disable-count, do, frame link, repeat use 14-bit unsigned counts.
// R13: Program counter is 23 bits over 24-bit program words.
// R14: Sequential execution advances PC by 2.
// R15: Active loop reloads loop_start_address after loop_end_address.
// R16: Exception loads vector, pushes PC+2; return_from_exception pops PC.
// R17: Branches add twice signed_word_displacement; false condition adds 2.
// R18: Absolute call loads target, pushes PC+4; absolute jump no stack.
// R19: Indirect call loads register, pushes PC+2; indirect jump no stack.
// R20: Relative call adds twice displacement or register, pushes PC+2.
// R21: Active repeat holds PC unchanged.
// R22: Subroutine returns pop the top of stack into PC.
// R23: Code generators should prefer the one-word relative call.
`default_nettype none
`include "opag_params.svh"
module opag_top #(
	parameter int DW = `OPAG_DW,
	parameter int PCW = `OPAG_PC_W
) (
	input  wire logic                    clk_in,
	input  wire logic                    nrst_in,
	// Generic indirect operand
	input  wire logic [DW-1:0]           ind_ptr_in,
	input  wire logic [DW-1:0]           ind_ofs_in,
	input  wire opag_pkg::opag_ind_mode_t ind_mode_in,
	input  wire logic                    ind_byte_in,
	input  wire logic                    ind_ofs_ok_in,
	input  wire logic                    ind_mod_en_in,
	input  wire logic                    ind_brev_en_in,
	input  wire logic [DW-1:0]           mod_start_in,
	input  wire logic [DW-1:0]           mod_end_in,
	input  wire logic [DW-1:0]           brev_span_in,
	output logic [DW-1:0]                ind_ea_out,
	output logic [DW-1:0]                ind_ptr_new_out,
	output logic                         ind_mode_err_out,
	// Dual prefetch
	input  wire logic                    pf_en_in,
	input  wire logic [DW-1:0]           x_prefetch_ptr_a_in,
	input  wire logic [DW-1:0]           x_prefetch_ptr_b_in,
	input  wire logic [DW-1:0]           y_prefetch_ptr_a_in,
	input  wire logic [DW-1:0]           y_prefetch_ptr_b_in,
	input  wire logic [DW-1:0]           dual_fetch_offset_reg_in,
	input  wire logic                    x_sel_b_in,
	input  wire logic                    y_sel_b_in,
	input  wire opag_pkg::opag_pf_mode_t x_mode_in,
	input  wire opag_pkg::opag_pf_mode_t y_mode_in,
	output logic [DW-1:0]                x_ea_out,
	output logic [DW-1:0]                y_ea_out,
	output logic [DW-1:0]                x_ptr_new_out,
	output logic [DW-1:0]                y_ptr_new_out,
	output logic                         x_ptr_we_out,
	output logic                         y_ptr_we_out,
	output logic                         x_sel_b_out,
	output logic                         y_sel_b_out,
	output logic                         pf_valid_out,
	// Immediate
	input  wire logic [DW-1:0]           imm_field_in,
	input  wire opag_pkg::opag_imm_kind_t imm_kind_in,
	output logic [DW-1:0]                imm_out,
	// Program counter and 14-bit count
	input  wire opag_pkg::opag_pc_op_t   pc_op_in,
	input  wire logic                    pc_step_in,
	input  wire logic                    cond_true_in,
	input  wire logic [DW-1:0]           signed_word_displacement_in,
	input  wire logic [PCW-1:0]          absolute_program_target_in,
	input  wire logic [PCW-1:0]          pointer_working_register_in,
	input  wire logic [PCW-1:0]          vector_addr_in,
	input  wire logic [PCW-1:0]          stack_top_in,
	input  wire logic                    loop_active_in,
	input  wire logic [PCW-1:0]          loop_start_address_in,
	input  wire logic [PCW-1:0]          loop_end_address_in,
	input  wire logic                    repeat_active_in,
	output logic [PCW-1:0]               pc_out,
	output logic                         push_out,
	output logic [PCW-1:0]               push_data_out,
	output logic                         pop_out,
	output logic [13:0]                  count14_out
);
	// Indirect-operand bit-reverse (increments only), else modulo, pointer update
	function automatic logic [DW-1:0] adj_ptr(input logic [DW-1:0] p,
		input logic [DW-1:0] upd, input logic mod_en, input logic brev_en,
		input logic [DW-1:0] ms, input logic [DW-1:0] me, input logic [DW-1:0] span,
		input logic down);
		logic [DW-1:0] r;
		logic [DW-1:0] off;
		r = upd;
		off = '0;
		// R9: used by the generic indirect operand only
		if (brev_en && !down) begin
			// R8: reversed carry add
			off = p & (span - 16'h0001);
			r = (p & ~(span - 16'h0001)) | (bitrev_add(off, span) & (span - 16'h0001));
		end else if (mod_en) begin
			// R7: wrap at bounds
			if (!down && p <= me && upd > me)
				r = ms + (upd - me - 16'h0001);
			else if (down && p >= ms && upd < ms)
				r = me - (ms - upd - 16'h0001);
		end
		return r;
	endfunction

	// Adds half the span with carries running toward bit 0
	function automatic logic [DW-1:0] bitrev_add(input logic [DW-1:0] v,
		input logic [DW-1:0] span);
		logic [DW-1:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = DW - 1; i >= 0; i--) begin
			if (((span >> 1) >> i) != 0 && c) begin
				c = r[i];
				r[i] = ~r[i];
			end
		end
		return r;
	endfunction

	// R3: step size per code
	function automatic logic [DW-1:0] pf_step(input logic [1:0] c);
		return DW'(c) * `OPAG_WORD_STEP;
	endfunction

	// R1: classic indirect modes
	wire logic [DW-1:0] ind_step = ind_byte_in ? `OPAG_BYTE_STEP : `OPAG_WORD_STEP;
	wire logic ind_dec = (ind_mode_in == opag_pkg::OPAG_IND_PREDEC) ||
		(ind_mode_in == opag_pkg::OPAG_IND_POSTDEC);
	wire logic ind_mv = (ind_mode_in != opag_pkg::OPAG_IND_NOMOD) &&
		(ind_mode_in != opag_pkg::OPAG_IND_REGOFS);
	wire logic [DW-1:0] ind_raw = ind_dec ? ind_ptr_in - ind_step : ind_ptr_in + ind_step;
	wire logic [DW-1:0] ind_upd = ind_mv ? adj_ptr(ind_ptr_in, ind_raw, ind_mod_en_in,
		ind_brev_en_in, mod_start_in, mod_end_in, brev_span_in, ind_dec) : ind_ptr_in;
	wire logic ind_pre = (ind_mode_in == opag_pkg::OPAG_IND_PREINC) ||
		(ind_mode_in == opag_pkg::OPAG_IND_PREDEC);
	wire logic ind_ofs = ind_mode_in == opag_pkg::OPAG_IND_REGOFS;
	// R1: offset only where allowed
	wire logic ind_bad = (ind_ofs && !ind_ofs_ok_in) || (ind_mode_in > opag_pkg::OPAG_IND_REGOFS);
	wire logic [DW-1:0] ind_ea = ind_ofs ? ind_ptr_in + ind_ofs_in :
		(ind_pre ? ind_upd : ind_ptr_in);

	// R5: only a/b pointer choice
	wire logic [DW-1:0] x_ptr = x_sel_b_in ? x_prefetch_ptr_b_in : x_prefetch_ptr_a_in;
	wire logic [DW-1:0] y_ptr = y_sel_b_in ? y_prefetch_ptr_b_in : y_prefetch_ptr_a_in;
	wire logic x_ro = x_mode_in == `OPAG_PF_REGOFS;
	wire logic y_ro = y_mode_in == `OPAG_PF_REGOFS;
	// R6: b pointer plus offset
	wire logic [DW-1:0] x_ea = x_ro ? x_prefetch_ptr_b_in + dual_fetch_offset_reg_in : x_ptr;
	wire logic [DW-1:0] y_ea = y_ro ? y_prefetch_ptr_b_in + dual_fetch_offset_reg_in : y_ptr;
	// R4: steps are 2/4/6 only
	wire logic [DW-1:0] x_upd = x_mode_in[2] ? x_ptr - pf_step(x_mode_in[1:0]) :
		x_ptr + pf_step(x_mode_in[1:0]);
	wire logic [DW-1:0] y_upd = y_mode_in[2] ? y_ptr - pf_step(y_mode_in[1:0]) :
		y_ptr + pf_step(y_mode_in[1:0]);
	wire logic x_we = pf_en_in && !x_ro && (x_mode_in[1:0] != 2'h0);
	wire logic y_we = pf_en_in && !y_ro && (y_mode_in[1:0] != 2'h0);

	// R11: sign or zero extension
	logic [DW-1:0] imm_ext;
	always_comb begin
		unique case (imm_kind_in)
			opag_pkg::OPAG_IMM_U1: imm_ext = {{(DW-1){1'b0}}, imm_field_in[0]};
			opag_pkg::OPAG_IMM_U4: imm_ext = {{(DW-4){1'b0}}, imm_field_in[3:0]};
			opag_pkg::OPAG_IMM_S4: imm_ext = {{(DW-4){imm_field_in[3]}}, imm_field_in[3:0]};
			opag_pkg::OPAG_IMM_U5: imm_ext = {{(DW-5){1'b0}}, imm_field_in[4:0]};
			opag_pkg::OPAG_IMM_S6: imm_ext = {{(DW-6){imm_field_in[5]}}, imm_field_in[5:0]};
			opag_pkg::OPAG_IMM_U8: imm_ext = {{(DW-8){1'b0}}, imm_field_in[7:0]};
			opag_pkg::OPAG_IMM_U10: imm_ext = {{(DW-10){1'b0}}, imm_field_in[9:0]};
			opag_pkg::OPAG_IMM_S10: imm_ext = {{(DW-10){imm_field_in[9]}}, imm_field_in[9:0]};
			default: imm_ext = '0;
		endcase
	end

	// Program counter next value
	logic [PCW-1:0] pc_r;
	logic [PCW-1:0] pc_nxt;
	logic push_nxt;
	logic [PCW-1:0] push_data_nxt;
	logic pop_nxt;
	wire logic [PCW-1:0] pc_seq = pc_r + `OPAG_PC_STEP;
	wire logic [PCW-1:0] disp2 = PCW'({{(PCW-DW){signed_word_displacement_in[DW-1]}},
		signed_word_displacement_in} << 1);
	wire logic [PCW-1:0] wn2 = PCW'(pointer_working_register_in << 1);
	always_comb begin
		// R14: plus two by default
		pc_nxt = pc_seq;
		push_nxt = 1'b0;
		push_data_nxt = pc_seq;
		pop_nxt = 1'b0;
		case (pc_op_in)
			// R17: branches
			opag_pkg::OPAG_PC_BRA: pc_nxt = pc_r + disp2;
			opag_pkg::OPAG_PC_BRC: pc_nxt = cond_true_in ? pc_r + disp2 : pc_seq;
			// R18: absolute target
			opag_pkg::OPAG_PC_CALL_ABS: begin
				pc_nxt = absolute_program_target_in;
				push_nxt = 1'b1;
				push_data_nxt = pc_r + `OPAG_PC_STEP2;
			end
			opag_pkg::OPAG_PC_GOTO_ABS: pc_nxt = absolute_program_target_in;
			// R19: register target
			opag_pkg::OPAG_PC_CALL_IND: begin
				pc_nxt = pointer_working_register_in;
				push_nxt = 1'b1;
			end
			opag_pkg::OPAG_PC_GOTO_IND: pc_nxt = pointer_working_register_in;
			// R20: relative calls
			opag_pkg::OPAG_PC_RELATIVE_SUBROUTINE_CALL: begin
				pc_nxt = pc_r + disp2;
				push_nxt = 1'b1;
			end
			opag_pkg::OPAG_PC_RELATIVE_SUBROUTINE_CALL_W: begin
				pc_nxt = pc_r + wn2;
				push_nxt = 1'b1;
			end
			// R16: exception entry
			opag_pkg::OPAG_PC_EXC: begin
				pc_nxt = vector_addr_in;
				push_nxt = 1'b1;
			end
			// R22: R16: pop returns
			opag_pkg::OPAG_PC_RET, opag_pkg::OPAG_PC_RETURN_FROM_EXCEPTION: begin
				pc_nxt = stack_top_in;
				pop_nxt = 1'b1;
			end
			default: begin
				// R15: loop wrap
				if (loop_active_in && pc_r == loop_end_address_in)
					pc_nxt = loop_start_address_in;
				// R21: repeat hold
				if (repeat_active_in)
					pc_nxt = pc_r;
			end
		endcase
		if (!pc_step_in) begin
			pc_nxt = pc_r;
			push_nxt = 1'b0;
			pop_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pc_r <= `OPAG_PC_RST;
			push_out <= 1'b0;
			push_data_out <= '0;
			pop_out <= 1'b0;
			count14_out <= '0;
			imm_out <= '0;
		end else begin
			// R13: 23-bit counter
			pc_r <= pc_nxt;
			push_out <= push_nxt;
			push_data_out <= push_data_nxt;
			pop_out <= pop_nxt;
			// R12: R10: 14-bit count field
			count14_out <= imm_field_in[13:0];
			imm_out <= (pc_op_in == opag_pkg::OPAG_PC_U16) ? imm_field_in : imm_ext;
		end
	end

	// R2: both fetches registered together
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			x_ea_out <= '0;
			y_ea_out <= '0;
			x_ptr_new_out <= '0;
			y_ptr_new_out <= '0;
			x_ptr_we_out <= 1'b0;
			y_ptr_we_out <= 1'b0;
			x_sel_b_out <= 1'b0;
			y_sel_b_out <= 1'b0;
			pf_valid_out <= 1'b0;
			ind_ea_out <= '0;
			ind_ptr_new_out <= '0;
			ind_mode_err_out <= 1'b0;
		end else begin
			x_ea_out <= x_ea;
			y_ea_out <= y_ea;
			x_ptr_new_out <= x_upd;
			y_ptr_new_out <= y_upd;
			x_ptr_we_out <= x_we;
			y_ptr_we_out <= y_we;
			x_sel_b_out <= x_sel_b_in;
			y_sel_b_out <= y_sel_b_in;
			pf_valid_out <= pf_en_in;
			ind_ea_out <= ind_ea;
			ind_ptr_new_out <= ind_upd;
			ind_mode_err_out <= ind_bad;
		end
	end

	assign pc_out = pc_r;

	property p_seq;
		@(posedge clk_in) disable iff (!nrst_in)
		(pc_step_in && pc_op_in == opag_pkg::OPAG_PC_SEQ && !loop_active_in &&
			!repeat_active_in) |=> pc_out == $past(pc_out) + `OPAG_PC_STEP;
	endproperty
	a_seq: assert property (p_seq) else $error("sequential step wrong"); // R14

	property p_rep;
		@(posedge clk_in) disable iff (!nrst_in)
		(pc_step_in && pc_op_in == opag_pkg::OPAG_PC_SEQ && repeat_active_in) |=> $stable(pc_out);
	endproperty
	a_rep: assert property (p_rep) else $error("repeat moved pc"); // R21

	property p_call;
		@(posedge clk_in) disable iff (!nrst_in)
		(pc_step_in && pc_op_in == opag_pkg::OPAG_PC_CALL_ABS) |=>
			push_out && push_data_out == $past(pc_out) + `OPAG_PC_STEP2;
	endproperty
	a_call: assert property (p_call) else $error("absolute call push wrong"); // R18

	property p_goto;
		@(posedge clk_in) disable iff (!nrst_in)
		(pc_step_in && pc_op_in == opag_pkg::OPAG_PC_GOTO_IND) |=>
			!push_out && pc_out == $past(pointer_working_register_in);
	endproperty
	a_goto: assert property (p_goto) else $error("indirect jump wrong"); // R19

	property p_ret;
		@(posedge clk_in) disable iff (!nrst_in)
		(pc_step_in && pc_op_in == opag_pkg::OPAG_PC_RET) |=>
			pop_out && pc_out == $past(stack_top_in);
	endproperty
	a_ret: assert property (p_ret) else $error("return pop wrong"); // R22

	property p_even;
		@(posedge clk_in) disable iff (!nrst_in)
		x_ptr_we_out |-> x_ptr_new_out[0] == x_ea_out[0];
	endproperty
	a_even: assert property (p_even) else $error("odd prefetch update"); // R4

	property p_ro;
		@(posedge clk_in) disable iff (!nrst_in)
		(pf_en_in && y_ro) |=> !y_ptr_we_out &&
			y_ea_out == $past(y_prefetch_ptr_b_in) + $past(dual_fetch_offset_reg_in);
	endproperty
	a_ro: assert property (p_ro) else $error("offset prefetch wrong"); // R6

	property p_brc;
		@(posedge clk_in) disable iff (!nrst_in)
		(pc_step_in && pc_op_in == opag_pkg::OPAG_PC_BRC && !cond_true_in) |=>
			pc_out == $past(pc_out) + `OPAG_PC_STEP;
	endproperty
	a_brc: assert property (p_brc) else $error("false branch wrong"); // R17
endmodule
`default_nettype wire

// >>> sim/opag_stack_model.sv
/*
 * Software stack in data memory, as the address generator sees it.
 * Assumes push and pop pulses are registered on clk_in, one per cycle.
 */
`default_nettype none
module opag_stack_model (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        push_in,
	input  wire logic [22:0] push_data_in,
	input  wire logic        pop_in,
	output logic [22:0]      stack_top_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [22:0]	mem_r [16];
	int		depth_r;

	// Empty stack shows a junk pattern, not the last popped value
	assign stack_top_out = (depth_r > 0) ? mem_r[depth_r-1] : 23'h2A_AAAA;

	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			depth_r <= 0;
		end else if (push_in && depth_r < 16) begin
			mem_r[depth_r] <= push_data_in;
			depth_r <= depth_r + 1;
		end else if (pop_in && depth_r > 0) begin
			depth_r <= depth_r - 1;
		end
	end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
 * Self-checking bench for the operand and program address generator.
 * Assumes registered outputs are valid 1 ns after the sampling edge.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [2:0] im; logic b; logic [15:0] iea, inew;
		logic [2:0] ik; logic [15:0] fld, imm;
		logic [2:0] xm; logic sb; logic [15:0] xea, xnew;
	} opag_row_t;

	localparam opag_row_t row_tab [8] = '{
	'{3'h0,1'b0,16'h1230,16'h1230,3'h0,16'hFFFF,16'h0001,3'h0,1'b0,16'h0800,16'h0800},
	'{3'h1,1'b0,16'h1232,16'h1232,3'h1,16'hFFFA,16'h000A,3'h1,1'b1,16'h0A00,16'h0A02},
	'{3'h2,1'b0,16'h122E,16'h122E,3'h2,16'h000A,16'hFFFA,3'h2,1'b0,16'h0800,16'h0804},
	'{3'h3,1'b0,16'h1230,16'h1232,3'h3,16'hFFF5,16'h0015,3'h3,1'b1,16'h0A00,16'h0A06},
	'{3'h4,1'b0,16'h1230,16'h122E,3'h4,16'h0025,16'hFFE5,3'h5,1'b0,16'h0800,16'h07FE},
	'{3'h5,1'b0,16'h1270,16'h1230,3'h5,16'h1280,16'h0080,3'h6,1'b1,16'h0A00,16'h09FC},
	'{3'h3,1'b1,16'h1230,16'h1231,3'h6,16'hFFFF,16'h03FF,3'h7,1'b0,16'h0800,16'h07FA},
	'{3'h2,1'b1,16'h122F,16'h122F,3'h7,16'h0200,16'hFE00,3'h4,1'b0,16'h0A10,16'h0000}};

	logic	clk_in, nrst_in, ind_byte_in, ind_ofs_ok_in, ind_mod_en_in, ind_brev_en_in;
	logic	pf_en_in, x_sel_b_in, y_sel_b_in, pc_step_in, cond_true_in;
	logic	loop_active_in, repeat_active_in, push_out, pop_out;
	logic	ind_mode_err_out, x_ptr_we_out, y_ptr_we_out, x_sel_b_out, y_sel_b_out;
	logic	pf_valid_out;
	logic [15:0]	ind_ptr_in, ind_ofs_in, mod_start_in, mod_end_in, brev_span_in;
	logic [15:0]	x_prefetch_ptr_a_in, x_prefetch_ptr_b_in, y_prefetch_ptr_a_in;
	logic [15:0]	y_prefetch_ptr_b_in, dual_fetch_offset_reg_in, imm_field_in;
	logic [15:0]	signed_word_displacement_in, ind_ea_out, ind_ptr_new_out, imm_out;
	logic [15:0]	x_ea_out, y_ea_out, x_ptr_new_out, y_ptr_new_out;
	logic [22:0]	absolute_program_target_in, pointer_working_register_in;
	logic [22:0]	vector_addr_in, stack_top_in, loop_start_address_in;
	logic [22:0]	loop_end_address_in, pc_out, push_data_out;
	logic [13:0]	count14_out;
	opag_pkg::opag_ind_mode_t	ind_mode_in;
	opag_pkg::opag_pf_mode_t	x_mode_in, y_mode_in;
	opag_pkg::opag_imm_kind_t	imm_kind_in;
	opag_pkg::opag_pc_op_t		pc_op_in;
	opag_row_t	r;
	int		bad_count, total_checks;

	opag_top DUT (.clk_in, .nrst_in, .ind_ptr_in, .ind_ofs_in, .ind_mode_in, .ind_byte_in,
		.ind_ofs_ok_in, .ind_mod_en_in, .ind_brev_en_in, .mod_start_in, .mod_end_in,
		.brev_span_in, .ind_ea_out, .ind_ptr_new_out, .ind_mode_err_out, .pf_en_in,
		.x_prefetch_ptr_a_in, .x_prefetch_ptr_b_in, .y_prefetch_ptr_a_in,
		.y_prefetch_ptr_b_in, .dual_fetch_offset_reg_in, .x_sel_b_in, .y_sel_b_in,
		.x_mode_in, .y_mode_in, .x_ea_out, .y_ea_out, .x_ptr_new_out, .y_ptr_new_out,
		.x_ptr_we_out, .y_ptr_we_out, .x_sel_b_out, .y_sel_b_out, .pf_valid_out,
		.imm_field_in, .imm_kind_in, .imm_out, .pc_op_in, .pc_step_in, .cond_true_in,
		.signed_word_displacement_in, .absolute_program_target_in,
		.pointer_working_register_in, .vector_addr_in, .stack_top_in, .loop_active_in,
		.loop_start_address_in, .loop_end_address_in, .repeat_active_in, .pc_out,
		.push_out, .push_data_out, .pop_out, .count14_out);

	opag_stack_model stk (.clk_in, .nrst_in, .push_in(push_out), .push_data_in(push_data_out),
		.pop_in(pop_out), .stack_top_out(stack_top_in));

	task automatic chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask

	task automatic pc_do(input opag_pkg::opag_pc_op_t op, input logic st, input logic [22:0] epc,
		input logic ep, input logic [22:0] ed, input logic eo);
		pc_op_in = op;
		pc_step_in = st;
		tick;
		chk("pc", pc_out, epc);
		chk("push", push_out, ep);
		chk("pop", pop_out, eo);
		if (ep)
			chk("push_data", push_data_out, ed);
	endtask

	task automatic ind_do(input logic [2:0] m, input logic [15:0] p, input logic [15:0] ea,
		input logic [15:0] nw);
		ind_mode_in = opag_pkg::opag_ind_mode_t'(m);
		ind_ptr_in = p;
		tick;
		chk("ind_ea", ind_ea_out, ea);
		chk("ind_new", ind_ptr_new_out, nw);
	endtask

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// Whole run is under 60 cycles
	initial begin
		#(50 * 2000);
		bad_count++;
		close_out;
	end

	initial begin
		bad_count = 0; total_checks = 0; nrst_in = 1'b0;
		ind_ptr_in = 16'h1230; ind_ofs_in = 16'h0040; ind_byte_in = 1'b0;
		ind_mode_in = opag_pkg::OPAG_IND_NOMOD; ind_ofs_ok_in = 1'b1;
		ind_mod_en_in = 1'b0; ind_brev_en_in = 1'b0; mod_start_in = 16'h1000;
		mod_end_in = 16'h100F; brev_span_in = 16'h0010; pf_en_in = 1'b1;
		x_prefetch_ptr_a_in = 16'h0800; x_prefetch_ptr_b_in = 16'h0A00;
		y_prefetch_ptr_a_in = 16'h0900; y_prefetch_ptr_b_in = 16'h0B00;
		dual_fetch_offset_reg_in = 16'h0010; x_sel_b_in = 1'b0; y_sel_b_in = 1'b0;
		x_mode_in = 3'h0; y_mode_in = 3'h0; imm_field_in = 16'h0000;
		imm_kind_in = opag_pkg::OPAG_IMM_U1; pc_op_in = opag_pkg::OPAG_PC_SEQ;
		pc_step_in = 1'b0; cond_true_in = 1'b0; signed_word_displacement_in = 16'h0010;
		absolute_program_target_in = 23'h40_0000; pointer_working_register_in = 23'h00_0100;
		vector_addr_in = 23'h00_0080; loop_active_in = 1'b0; repeat_active_in = 1'b0;
		loop_start_address_in = 23'h00_0080; loop_end_address_in = 23'h00_0102;
		repeat (8) @(posedge clk_in);
		chk("rst_pc", pc_out, 23'h00_0000);
		chk("rst_push", push_out, 1'b0);
		#1 nrst_in = 1'b1;
		foreach (row_tab[i]) begin
			r = row_tab[i];
			ind_mode_in = opag_pkg::opag_ind_mode_t'(r.im);
			ind_byte_in = r.b;
			imm_kind_in = opag_pkg::opag_imm_kind_t'(r.ik);
			imm_field_in = r.fld;
			x_mode_in = r.xm; y_mode_in = r.xm; x_sel_b_in = r.sb; y_sel_b_in = r.sb;
			tick;
			chk("ind_ea", ind_ea_out, r.iea);
			chk("ind_new", ind_ptr_new_out, r.inew);
			chk("ind_err", ind_mode_err_out, 1'b0);
			chk("imm", imm_out, r.imm);
			chk("count14", count14_out, r.fld[13:0]);
			chk("x_ea", x_ea_out, r.xea);
			chk("y_ea", y_ea_out, r.xea + 16'h0100);
			chk("sel_echo", {x_sel_b_out, y_sel_b_out}, {r.sb, r.sb});
			chk("pf_valid", pf_valid_out, 1'b1);
			if (r.xm != 3'h4) chk("x_new", x_ptr_new_out, r.xnew);
			if (r.xm != 3'h4) chk("y_new", y_ptr_new_out, r.xnew + 16'h0100);
			chk("x_we", x_ptr_we_out, r.xm != 3'h0 && r.xm != 3'h4);
			chk("y_we", y_ptr_we_out, r.xm != 3'h0 && r.xm != 3'h4);
		end
		pf_en_in = 1'b0;
		x_mode_in = 3'h1;
		tick;
		chk("pf_valid_off", pf_valid_out, 1'b0);
		chk("x_we_off", x_ptr_we_out, 1'b0);
		pf_en_in = 1'b1;
		ind_byte_in = 1'b0;
		ind_ofs_ok_in = 1'b0;
		ind_do(3'h5, 16'h1230, 16'h1270, 16'h1230);
		chk("ind_err", ind_mode_err_out, 1'b1);
		ind_ofs_ok_in = 1'b1;
		ind_mod_en_in = 1'b1;
		ind_do(3'h3, 16'h100E, 16'h100E, 16'h1000);
		ind_do(3'h4, 16'h1000, 16'h1000, 16'h100E);
		ind_mod_en_in = 1'b0;
		ind_brev_en_in = 1'b1;
		ind_do(3'h3, 16'h2008, 16'h2008, 16'h2004);
		ind_brev_en_in = 1'b0;
		imm_field_in = 16'hA5C3;
		pc_do(opag_pkg::OPAG_PC_U16, 1'b0, 23'h00_0000, 1'b0, 23'h0, 1'b0);
		chk("imm16", imm_out, 16'hA5C3);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0002, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_BRA, 1'b1, 23'h00_0022, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_BRC, 1'b1, 23'h00_0024, 1'b0, 23'h0, 1'b0);
		cond_true_in = 1'b1;
		signed_word_displacement_in = 16'hFFF0;
		pc_do(opag_pkg::OPAG_PC_BRC, 1'b1, 23'h00_0004, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_CALL_ABS, 1'b1, 23'h40_0000, 1'b1, 23'h00_0008, 1'b0);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b0, 23'h40_0000, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_RET, 1'b1, 23'h00_0008, 1'b0, 23'h0, 1'b1);
		absolute_program_target_in = 23'h12_3456;
		pc_do(opag_pkg::OPAG_PC_GOTO_ABS, 1'b1, 23'h12_3456, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_CALL_IND, 1'b1, 23'h00_0100, 1'b1, 23'h12_3458, 1'b0);
		pointer_working_register_in = 23'h00_0200;
		pc_do(opag_pkg::OPAG_PC_GOTO_IND, 1'b1, 23'h00_0200, 1'b0, 23'h0, 1'b0);
		signed_word_displacement_in = 16'h0008;
		pc_do(opag_pkg::OPAG_PC_RELATIVE_SUBROUTINE_CALL, 1'b1, 23'h00_0210, 1'b1, 23'h00_0202, 1'b0);
		pointer_working_register_in = 23'h00_0010;
		pc_do(opag_pkg::OPAG_PC_RELATIVE_SUBROUTINE_CALL_W, 1'b1, 23'h00_0230, 1'b1, 23'h00_0212, 1'b0);
		pc_do(opag_pkg::OPAG_PC_EXC, 1'b1, 23'h00_0080, 1'b1, 23'h00_0232, 1'b0);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b0, 23'h00_0080, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_RETURN_FROM_EXCEPTION, 1'b1, 23'h00_0232, 1'b0, 23'h0, 1'b1);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b0, 23'h00_0232, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_RET, 1'b1, 23'h00_0212, 1'b0, 23'h0, 1'b1);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b0, 23'h00_0212, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_RET, 1'b1, 23'h00_0202, 1'b0, 23'h0, 1'b1);
		absolute_program_target_in = 23'h00_0100;
		pc_do(opag_pkg::OPAG_PC_GOTO_ABS, 1'b1, 23'h00_0100, 1'b0, 23'h0, 1'b0);
		loop_active_in = 1'b1;
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0102, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0080, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0082, 1'b0, 23'h0, 1'b0);
		loop_active_in = 1'b0;
		repeat_active_in = 1'b1;
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0082, 1'b0, 23'h0, 1'b0);
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0082, 1'b0, 23'h0, 1'b0);
		repeat_active_in = 1'b0;
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0084, 1'b0, 23'h0, 1'b0);
		// Second reset lands mid-run, checked before any edge
		nrst_in = 1'b0;
		#5;
		chk("rst_pc", pc_out, 23'h00_0000);
		tick;
		tick;
		nrst_in = 1'b1;
		pc_do(opag_pkg::OPAG_PC_SEQ, 1'b1, 23'h00_0002, 1'b0, 23'h0, 1'b0);
		close_out;
	end
endmodule
`default_nettype wire
